// ### rtl/i2c_status_consts.svh
// Summary of operation
// - Second-address hit bit shows which own address matched; cleared on stop/restart/disable.
// - Host header flag only with host type and address resolution enabled.
// - Default address flag only with address resolution enabled; same clears.
// - General call flag only with general call enabled; same clears.
// - Transmit direction taken from R/W bit at end of address phase.
// - Transmit direction cleared on stop, restart, arbitration loss or disable.
// - Busy set on SDA or SCL low, cleared by stop, even disabled.
// - Master flag set with start-generated flag; cleared by stop, arbitration loss, disable.
// - Status3 read following status1 read clears the address flag.
// - Last-transfer control marks next DMA end as final; NACK last byte in master receive mode only.
// - DMA request raised when enabled and tx empty or rx full.
// - Buffer flags raise event interrupt only with buffer interrupt enable.
// - Event interrupt on start, address, header, stop, byte finished, wakeup.
// - Error interrupt on any bus, arbitration, ack, overrun, checksum, timeout, alert.
// - Speed select 0 picks standard timing, 1 picks fast timing.
// - Standard mode: SCL high and low each one divider count.
// - Fast mode duty 0: high one count, low two counts.
// - Fast mode duty 1: high nine counts, low sixteen counts.
// - Arbitration loss returns to slave, clearing master flag.
//
// Purpose: register offsets, reset values and field positions
// Assumes: byte address = 4 * printed index on Avalon-MM
// Notes: index 0x02 collides with frequency setting; kept as given
`ifndef I2C_STATUS_CONSTS_SVH
`define I2C_STATUS_CONSTS_SVH
`define IDX_CLK_DIV_LOW 4'h2
`define IDX_BUS_STATE 4'h9
`define IDX_IRQ_DMA_CTRL 4'hA
`define IDX_CLK_DIV_HIGH 4'hC
`define IDX_STATUS1 4'h7
`define RST_CLK_DIV_LOW 8'h0B
`define RST_BUS_STATE 8'h00
`define RST_IRQ_DMA_CTRL 8'h00
`define RST_CLK_DIV_HIGH 8'h00
`define BIT_FAST 7
`define BIT_DUTY 6
`define BIT_LAST 4
`define BIT_DMA_REQUEST_ENABLE 3
`define BIT_BUFEN 2
`define BIT_EVTEN 1
`define BIT_ERREN 0
`define MUL_DUTY_HIGH 5'h09
`define MUL_DUTY_LOW 5'h10
`endif

// ### rtl/i2c_status_pkg.sv
// Purpose: shared types for the status and clock block
// Assumes: nothing
// Notes: event groups carried as packed structs
package i2c_status_pkg;
    typedef struct packed {
        logic start_generated_flag;
        logic address_flag;
        logic ten_bit_header_sent;
        logic stop_seen_flag;
        logic byte_finished_flag;
        logic tx_empty_flag;
        logic rx_full_flag;
        logic halt_wakeup_flag;
    } event_flags_t;
    typedef struct packed {
        logic misplaced_condition_error;
        logic arbitration_lost_flag;
        logic ack_failure_flag;
        logic over_under_run_flag;
        logic checksum_error_flag;
        logic timeout_flag;
        logic smbus_alert_flag;
    } error_flags_t;
    typedef struct packed {
        logic addr_match;
        logic second_own;
        logic host_header;
        logic default_addr;
        logic general_call;
        logic rw_bit;
    } addr_info_t;
    typedef enum logic [1:0] {SCL_IDLE, SCL_HIGH, SCL_LOW} scl_state_t;
endpackage : i2c_status_pkg

// ### rtl/i2c_status_irq_clockgen.sv
// Purpose: status 3, interrupt/DMA control and SCL generator
// Assumes: bus pins synchronous to mclk; events are one-cycle pulses
// Notes: registers answer with one wait cycle
`include "i2c_status_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module i2c_status_irq_clockgen
    import i2c_status_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Controller side
    input wire logic peripheral_enable,
    input wire logic smbus_host_type,
    input wire logic address_resolution_enable,
    input wire logic general_call_enable,
    input wire logic status1_read,
    input wire event_flags_t events,
    input wire error_flags_t errors,
    input wire addr_info_t addr_info,
    input wire logic restart_seen,
    input wire logic stop_seen,
    input wire logic scl_run,
    input wire logic dma_end_of_transfer,
    output logic address_flag_clear,
    output logic last_byte_nack,
    output logic dma_request,
    output logic event_irq,
    output logic error_irq,
    // Bus pins
    input wire logic sda_in,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe
);
    logic [7:0] clk_div_low_r;
    logic [7:0] clk_div_high_r;
    logic [4:0] irq_dma_r;
    logic second_own_address_hit_r;
    logic smbus_host_header_seen_r;
    logic smbus_default_address_seen_r;
    logic general_call_seen_r;
    logic transmit_direction_r;
    logic bus_busy_r;
    logic master_mode_flag_r;
    logic status1_seen_r;
    logic ack_r;
    logic [31:0] readdata_r;
    logic last_armed_r;
    scl_state_t scl_state_r;
    logic [16:0] scl_count_r;
    logic clear_all;
    logic acc;
    logic [3:0] idx;
    logic [7:0] status3;
    logic [11:0] scl_divider;
    logic [16:0] high_count;
    logic [16:0] low_count;

    // Scale divider by a phase multiplier
    function automatic logic [16:0] scale(input logic [11:0] d,
                                          input logic [4:0] m);
        scale = 17'(d) * 17'(m);
    endfunction : scale

    assign idx = address[5:2];
    assign acc = (read | write) & ~ack_r;
    assign waitrequest = (read | write) & ~ack_r;
    assign readdata = readdata_r;
    assign clear_all = stop_seen | restart_seen | ~peripheral_enable;
    assign scl_divider = {clk_div_high_r[3:0], clk_div_low_r};
    assign status3 = {second_own_address_hit_r, smbus_host_header_seen_r,
                      smbus_default_address_seen_r, general_call_seen_r,
                      1'b0, transmit_direction_r, bus_busy_r,
                      master_mode_flag_r};

    // One wait cycle then answer
    always_ff @(posedge mclk)
    begin
        if (reset)
            ack_r <= 1'b0;
        else
            ack_r <= acc;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            readdata_r <= 32'h0000_0000;
        else if (acc && read)
        begin
            case (idx)
                `IDX_CLK_DIV_LOW: readdata_r <= {24'h0, clk_div_low_r};
                `IDX_BUS_STATE: readdata_r <= {24'h0, status3};
                `IDX_IRQ_DMA_CTRL: readdata_r <= {27'h0, irq_dma_r};
                `IDX_CLK_DIV_HIGH: readdata_r <= {24'h0, clk_div_high_r[7:6],
                                                  2'b00, clk_div_high_r[3:0]};
                default: readdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // software writes divider only when disabled
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            clk_div_low_r <= `RST_CLK_DIV_LOW;
            clk_div_high_r <= `RST_CLK_DIV_HIGH;
            irq_dma_r <= 5'(`RST_IRQ_DMA_CTRL);
        end
        else if (ack_r && write)
        begin
            if (idx == `IDX_CLK_DIV_LOW)
                clk_div_low_r <= writedata[7:0];
            if (idx == `IDX_CLK_DIV_HIGH)
                clk_div_high_r <= {writedata[7:6], 2'b00, writedata[3:0]};
            if (idx == `IDX_IRQ_DMA_CTRL)
                irq_dma_r <= writedata[4:0];
        end
    end

    // status1 then status3 read clears address flag
    always_ff @(posedge mclk)
    begin
        if (reset)
            status1_seen_r <= 1'b0;
        else if (acc && read && idx == `IDX_BUS_STATE)
            status1_seen_r <= 1'b0;
        else if (status1_read)
            status1_seen_r <= 1'b1;
    end
    assign address_flag_clear = acc & read & (idx == `IDX_BUS_STATE)
                                & status1_seen_r;

    always_ff @(posedge mclk)
    begin
        if (reset || clear_all)
            second_own_address_hit_r <= 1'b0;
        else if (addr_info.addr_match)
            second_own_address_hit_r <= addr_info.second_own;
    end

    always_ff @(posedge mclk)
    begin
        if (reset || clear_all)
        begin
            smbus_host_header_seen_r <= 1'b0;
            smbus_default_address_seen_r <= 1'b0;
            general_call_seen_r <= 1'b0;
        end
        else if (addr_info.addr_match)
        begin
            smbus_host_header_seen_r <= addr_info.host_header
                & smbus_host_type & address_resolution_enable;
            smbus_default_address_seen_r <= addr_info.default_addr
                & address_resolution_enable;
            general_call_seen_r <= addr_info.general_call
                & general_call_enable;
        end
    end

    // direction cleared on stop, restart, loss, disable
    always_ff @(posedge mclk)
    begin
        if (reset || clear_all || errors.arbitration_lost_flag)
            transmit_direction_r <= 1'b0;
        else if (events.address_flag)
            transmit_direction_r <= addr_info.rw_bit;
    end

    // busy tracks the lines even when disabled
    always_ff @(posedge mclk)
    begin
        if (reset)
            bus_busy_r <= 1'b0;
        else if (!sda_in || !scl_in)
            bus_busy_r <= 1'b1;
        else if (stop_seen)
            bus_busy_r <= 1'b0;
    end

    // master flag, dropped on loss or stop
    always_ff @(posedge mclk)
    begin
        if (reset || stop_seen || errors.arbitration_lost_flag
            || !peripheral_enable)
            master_mode_flag_r <= 1'b0;
        else if (events.start_generated_flag)
            master_mode_flag_r <= 1'b1;
    end

    // last transfer arms NACK on next DMA end
    always_ff @(posedge mclk)
    begin
        if (reset || !peripheral_enable)
            last_armed_r <= 1'b0;
        else if (dma_end_of_transfer)
            last_armed_r <= irq_dma_r[`BIT_LAST];
    end
    assign last_byte_nack = last_armed_r & master_mode_flag_r
                            & ~transmit_direction_r;

    assign dma_request = irq_dma_r[`BIT_DMA_REQUEST_ENABLE]
                         & (events.tx_empty_flag | events.rx_full_flag);

    assign event_irq = irq_dma_r[`BIT_EVTEN]
        & (events.start_generated_flag | events.address_flag
           | events.ten_bit_header_sent | events.stop_seen_flag
           | events.byte_finished_flag | events.halt_wakeup_flag
           | (irq_dma_r[`BIT_BUFEN]
              & (events.tx_empty_flag | events.rx_full_flag)));

    assign error_irq = irq_dma_r[`BIT_ERREN] & (|errors);

    always_comb
    begin
        high_count = 17'(scl_divider);
        low_count = 17'(scl_divider);
        if (clk_div_high_r[`BIT_FAST])
        begin
            if (clk_div_high_r[`BIT_DUTY])
            begin
                high_count = scale(scl_divider, `MUL_DUTY_HIGH);
                low_count = scale(scl_divider, `MUL_DUTY_LOW);
            end
            else
                low_count = scale(scl_divider, 5'h02);
        end
    end

    // counter restarts at every phase change
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            scl_state_r <= SCL_IDLE;
            scl_count_r <= 17'h00001;
        end
        else
        begin
            case (scl_state_r)
                SCL_IDLE:
                    if (scl_run && peripheral_enable)
                    begin
                        scl_state_r <= SCL_LOW;
                        scl_count_r <= 17'h00001;
                    end
                SCL_LOW:
                    if (scl_count_r >= low_count)
                    begin
                        scl_state_r <= SCL_HIGH;
                        scl_count_r <= 17'h00001;
                    end
                    else
                        scl_count_r <= scl_count_r + 17'h00001;
                SCL_HIGH:
                    if (scl_count_r >= high_count)
                    begin
                        scl_state_r <= (scl_run && peripheral_enable)
                                       ? SCL_LOW : SCL_IDLE;
                        scl_count_r <= 17'h00001;
                    end
                    else
                        scl_count_r <= scl_count_r + 17'h00001;
                default:
                    scl_state_r <= SCL_IDLE;
            endcase
        end
    end
    assign scl_out = 1'b0;
    assign scl_oe = (scl_state_r == SCL_LOW);

    // master flag follows start within one cycle
    a_master_set: assert property (@(posedge mclk) disable iff (reset)
        events.start_generated_flag && peripheral_enable && !stop_seen
        && !errors.arbitration_lost_flag |=> master_mode_flag_r)
        else $error("master flag not set after start");
    a_loss_slave: assert property (@(posedge mclk) disable iff (reset)
        errors.arbitration_lost_flag |=> !master_mode_flag_r
        && !transmit_direction_r)
        else $error("arbitration loss left master state");
    a_busy_low: assert property (@(posedge mclk) disable iff (reset)
        !sda_in |=> bus_busy_r)
        else $error("busy not set on low line");
    a_disable_clear: assert property (@(posedge mclk) disable iff (reset)
        !peripheral_enable |=> status3[7:4] == 4'h0)
        else $error("slave flags survived disable");
    // Request must follow the enable both ways
    a_dma_on: assert property (@(posedge mclk) disable iff (reset)
        irq_dma_r[`BIT_DMA_REQUEST_ENABLE]
        && (events.tx_empty_flag || events.rx_full_flag) |-> dma_request)
        else $error("dma request missing");
    a_dma_off: assert property (@(posedge mclk) disable iff (reset)
        !irq_dma_r[`BIT_DMA_REQUEST_ENABLE] |-> !dma_request)
        else $error("dma request while disabled");
    a_buf_gate: assert property (@(posedge mclk) disable iff (reset)
        !irq_dma_r[`BIT_BUFEN] && (events == 8'h02 || events == 8'h04
        || events == 8'h06) |-> !event_irq)
        else $error("buffer event raised interrupt");
    a_err_irq: assert property (@(posedge mclk) disable iff (reset)
        irq_dma_r[`BIT_ERREN] && errors.timeout_flag |-> error_irq)
        else $error("error interrupt missing");
    a_std_high: assert property (@(posedge mclk) disable iff (reset)
        !clk_div_high_r[`BIT_FAST] |-> high_count == low_count)
        else $error("standard phases unequal");
    a_fast_ratio: assert property (@(posedge mclk) disable iff (reset)
        clk_div_high_r[`BIT_FAST] && !clk_div_high_r[`BIT_DUTY]
        |-> low_count == 17'(high_count << 1))
        else $error("fast duty 0 ratio wrong");
    a_scl_rel: assert property (@(posedge mclk) disable iff (reset)
        $rose(scl_oe) |-> scl_count_r == 17'h00001)
        else $error("low phase did not restart count");
    a_evt_gate: assert property (@(posedge mclk) disable iff (reset)
        !irq_dma_r[`BIT_EVTEN] |-> !event_irq)
        else $error("event interrupt while disabled");
    a_err_gate: assert property (@(posedge mclk) disable iff (reset)
        !irq_dma_r[`BIT_ERREN] |-> !error_irq)
        else $error("error interrupt while disabled");
    a_fast_duty: assert property (@(posedge mclk) disable iff (reset)
        clk_div_high_r[`BIT_FAST] && clk_div_high_r[`BIT_DUTY]
        |-> high_count == 17'(scl_divider) * 17'(`MUL_DUTY_HIGH)
        && low_count == 17'(scl_divider) * 17'(`MUL_DUTY_LOW))
        else $error("fast duty 1 phases wrong");
    a_tra_set: assert property (@(posedge mclk) disable iff (reset)
        events.address_flag && !clear_all && !errors.arbitration_lost_flag
        |=> transmit_direction_r == $past(addr_info.rw_bit))
        else $error("direction not taken from address byte");
    a_tra_clear: assert property (@(posedge mclk) disable iff (reset)
        clear_all |=> !transmit_direction_r)
        else $error("direction survived stop or disable");
    a_last_arm: assert property (@(posedge mclk) disable iff (reset)
        dma_end_of_transfer && peripheral_enable && irq_dma_r[`BIT_LAST]
        |=> last_armed_r)
        else $error("last transfer not armed");
    a_busy_stop: assert property (@(posedge mclk) disable iff (reset)
        stop_seen && sda_in && scl_in |=> !bus_busy_r)
        else $error("busy not cleared by stop");
    a_host_qual: assert property (@(posedge mclk) disable iff (reset)
        addr_info.addr_match && !smbus_host_type |=> !smbus_host_header_seen_r)
        else $error("host header flag without host type");
    a_gc_qual: assert property (@(posedge mclk) disable iff (reset)
        addr_info.addr_match && !general_call_enable
        |=> !general_call_seen_r)
        else $error("general call flag while disabled");
    a_clear_once: assert property (@(posedge mclk) disable iff (reset)
        address_flag_clear |=> !status1_seen_r)
        else $error("address clear armed twice");

    sequence s_low_done;
        scl_state_r == SCL_LOW && scl_count_r >= low_count;
    endsequence : s_low_done
    sequence s_high_fresh;
        scl_state_r == SCL_HIGH && scl_count_r == 17'h00001;
    endsequence : s_high_fresh
    a_low_to_high: assert property (@(posedge mclk) disable iff (reset)
        s_low_done |=> s_high_fresh)
        else $error("high phase did not restart count");
endmodule : i2c_status_irq_clockgen
`default_nettype wire

// ### testbench/i2c_bus_partner.sv
// Purpose: far side of the two-wire bus, resolving the SCL wire
// Assumes: pull-up on SCL; other parties can only pull low
// Notes: stretch stands for a slow slave holding the clock low
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_partner
(
    // Design side
    input wire logic scl_oe,
    input wire logic scl_out,
    // Far side control
    input wire logic stretch,
    // Resolved wire
    output logic scl_line
);
    // Pull-up wins unless someone drives low
    assign scl_line = !((scl_oe && !scl_out) || stretch);
endmodule : i2c_bus_partner
`default_nettype wire

// ### testbench/i2c_status_irq_clockgen_tb.sv
// Purpose: self-checking bench for status, irq and SCL block
// Assumes: one wait state on every register access
// Notes: divider and mode are written only while disabled
`include "i2c_status_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module i2c_status_irq_clockgen_tb
    import i2c_status_pkg::*;
;
    logic mclk, reset, read, write, en, host_type, arp_en, gc_en;
    logic scl_run, stretch, sda_in, scl_line, scl_out, scl_oe;
    logic waitrequest, afc_o, afc, nack, dma_req, evt_irq, err_irq;
    logic [5:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] pulses;
    logic [7:0] d;
    event_flags_t events;
    error_flags_t errors;
    addr_info_t ainfo;
    int error_cnt, n_tests, hi, lo;
    logic [7:0] mh [4] = '{8'h00, 8'h80, 8'hC0, 8'h01};
    logic [7:0] ml [4] = '{8'h04, 8'h04, 8'h01, 8'h05};
    int eh [4] = '{4, 4, 9 * 1, 261};
    int el [4] = '{4, 2 * 4, 16 * 1, 261};

    i2c_status_irq_clockgen uut (.mclk(mclk), .reset(reset),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .peripheral_enable(en),
        .smbus_host_type(host_type), .address_resolution_enable(arp_en),
        .general_call_enable(gc_en), .status1_read(pulses[2]),
        .events(events), .errors(errors), .addr_info(ainfo),
        .restart_seen(pulses[0]), .stop_seen(pulses[1]),
        .scl_run(scl_run), .dma_end_of_transfer(pulses[3]),
        .address_flag_clear(afc_o), .last_byte_nack(nack),
        .dma_request(dma_req), .event_irq(evt_irq), .error_irq(err_irq),
        .sda_in(sda_in), .scl_in(scl_line), .scl_out(scl_out),
        .scl_oe(scl_oe));
    i2c_bus_partner far (.scl_oe(scl_oe), .scl_out(scl_out),
        .stretch(stretch), .scl_line(scl_line));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic bus_write(input logic [3:0] idx, input logic [7:0] v);
        address <= {idx, 2'b00};
        writedata <= {24'h000000, v};
        write <= 1'b1;
        @(posedge mclk);
        while (waitrequest !== 1'b0)
            @(posedge mclk);
        write <= 1'b0;
        @(posedge mclk);
    endtask : bus_write

    task automatic bus_read(input logic [3:0] idx, output logic [7:0] v);
        address <= {idx, 2'b00};
        read <= 1'b1;
        @(posedge mclk);
        // Clear pulse belongs to the first access cycle
        afc = afc_o;
        while (waitrequest !== 1'b0)
            @(posedge mclk);
        v = readdata[7:0];
        read <= 1'b0;
        @(posedge mclk);
    endtask : bus_read

    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp,
        input string what);
        logic [7:0] v;
        bus_read(idx, v);
        check(what, v, exp);
    endtask : rd_chk

    task automatic ev(input event_flags_t e, input error_flags_t r,
        input logic [2:0] exp);
        events <= e;
        errors <= r;
        #1;
        check("irq_dma", {evt_irq, err_irq, dma_req}, exp);
        @(posedge mclk);
        events <= '0;
        errors <= '0;
        @(posedge mclk);
    endtask : ev

    task automatic pulse(input int i);
        pulses[i] <= 1'b1;
        @(posedge mclk);
        pulses <= '0;
        @(posedge mclk);
    endtask : pulse

    task automatic hit(input addr_info_t a);
        // Match and end of address phase arrive together
        ainfo <= a;
        events.address_flag <= 1'b1;
        @(posedge mclk);
        ainfo <= '0;
        events <= '0;
        @(posedge mclk);
    endtask : hit

    task automatic wait_oe(input logic v, output int n);
        n = 0;
        while (scl_oe !== v)
        begin
            @(posedge mclk);
            n++;
        end
    endtask : wait_oe

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        complete_run();
    end

    initial
    begin
        {read, write, en, host_type, arp_en, gc_en, scl_run, stretch} = '0;
        {address, writedata, pulses, events, errors, ainfo} = '0;
        sda_in = 1'b1;
        reset = 1'b1;
        error_cnt = 0;
        n_tests = 0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd_chk(`IDX_CLK_DIV_LOW, `RST_CLK_DIV_LOW, "div_low");
        rd_chk(`IDX_BUS_STATE, `RST_BUS_STATE, "bus_state");
        rd_chk(`IDX_IRQ_DMA_CTRL, `RST_IRQ_DMA_CTRL, "irq_dma");
        rd_chk(`IDX_CLK_DIV_HIGH, `RST_CLK_DIV_HIGH, "div_high");
        rd_chk(4'h3, 8'h00, "unmapped");
        bus_write(`IDX_BUS_STATE, 8'hFF);
        rd_chk(`IDX_BUS_STATE, 8'h00, "bus_state_ro");
        bus_write(`IDX_IRQ_DMA_CTRL, 8'h1F);
        rd_chk(`IDX_IRQ_DMA_CTRL, 8'h1F, "irq_dma_rw");
        bus_write(`IDX_CLK_DIV_HIGH, 8'hCF);
        rd_chk(`IDX_CLK_DIV_HIGH, 8'hCF, "div_high_rw");
        en <= 1'b1;
        // Buffer flags stay silent without buffer enable
        bus_write(`IDX_IRQ_DMA_CTRL, 8'h03);
        for (int i = 0; i < 8; i++)
            ev(event_flags_t'(8'h01 << i), 7'h00,
                (i == 1 || i == 2) ? 3'b000 : 3'b100);
        for (int i = 0; i < 7; i++)
            ev(8'h00, error_flags_t'(7'h01 << i), 3'b010);
        bus_write(`IDX_IRQ_DMA_CTRL, 8'h0E);
        ev(8'h04, 7'h00, 3'b101);
        ev(8'h02, 7'h00, 3'b101);
        bus_write(`IDX_IRQ_DMA_CTRL, 8'h00);
        ev(8'h02, 7'h7F, 3'b000);
        en <= 1'b0;
        @(posedge mclk);
        en <= 1'b1;
        gc_en <= 1'b1;
        arp_en <= 1'b1;
        hit(6'h3F);
        rd_chk(`IDX_BUS_STATE, 8'hB4, "match_all");
        pulse(0);
        rd_chk(`IDX_BUS_STATE, 8'h00, "restart");
        host_type <= 1'b1;
        gc_en <= 1'b0;
        hit(6'h2A);
        rd_chk(`IDX_BUS_STATE, 8'h40, "host_only");
        pulse(1);
        rd_chk(`IDX_BUS_STATE, 8'h00, "stop");
        ev(8'h80, 7'h00, 3'b000);
        hit(6'h21);
        rd_chk(`IDX_BUS_STATE, 8'h05, "master_tx");
        ev(8'h00, 7'h20, 3'b000);
        rd_chk(`IDX_BUS_STATE, 8'h00, "arb_lost");
        hit(6'h30);
        rd_chk(`IDX_BUS_STATE, 8'h80, "second_own");
        en <= 1'b0;
        @(posedge mclk);
        rd_chk(`IDX_BUS_STATE, 8'h00, "disabled");
        // Far side pulls both lines low while disabled
        stretch <= 1'b1;
        sda_in <= 1'b0;
        @(posedge mclk);
        stretch <= 1'b0;
        sda_in <= 1'b1;
        rd_chk(`IDX_BUS_STATE, 8'h02, "busy");
        pulse(1);
        rd_chk(`IDX_BUS_STATE, 8'h00, "busy_stop");
        en <= 1'b1;
        pulse(2);
        bus_read(`IDX_BUS_STATE, d);
        check("addr_clear", afc, 1'b1);
        bus_read(`IDX_BUS_STATE, d);
        check("no_clear", afc, 1'b0);
        ev(8'h80, 7'h00, 3'b000);
        pulse(3);
        check("nack_off", nack, 1'b0);
        bus_write(`IDX_IRQ_DMA_CTRL, 8'h10);
        pulse(3);
        check("nack_on", nack, 1'b1);
        for (int m = 0; m < 4; m++)
        begin
            en <= 1'b0;
            scl_run <= 1'b0;
            repeat (30) @(posedge mclk);
            bus_write(`IDX_CLK_DIV_HIGH, mh[m]);
            bus_write(`IDX_CLK_DIV_LOW, ml[m]);
            en <= 1'b1;
            scl_run <= 1'b1;
            wait_oe(1'b1, lo);
            wait_oe(1'b0, lo);
            wait_oe(1'b1, hi);
            wait_oe(1'b0, lo);
            check("scl_high", hi, eh[m]);
            check("scl_low", lo, el[m]);
        end
        complete_run();
    end
endmodule : i2c_status_irq_clockgen_tb
`default_nettype wire
